/* adc_cfg.svh */
// Purpose: Constants of the converter control block
// Assumes: APB byte addresses, 100 MHz pclk
// Notes:   Definitions only
`ifndef ADC_CFG_SVH
`define ADC_CFG_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define ADDR_W            8
`define OFF_MODE          8'h00
`define OFF_CHAN          8'h04
`define OFF_RESULT        8'h08
`define OFF_STATUS        8'h0C
`define OFF_MASK          8'h10
`define OFF_DAC_MODE      8'h14

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define RUN_BIT           7
`define CHAN_MSB          2
`define CHAN_MAX          3'h4
`define DONE_BIT          0
`define VALID_BIT         1
`define DAC_EN_BIT        0
`define RST_CHAN          3'h0
`define RST_RESULT        8'h00
`define RD_ZERO           32'h0000_0000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS     10
`define SAMPLE_TIME_NS    80
`define SAMPLE_CYCLES     4'((`SAMPLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SAR_MSB           3'h7
`define SAR_FIRST_CODE    8'h80

`endif

/* adc_pkg.sv */
// Purpose: Types of the converter control block
// Assumes: Constants come from adc_cfg.svh
// Notes:   State of each module is one packed struct
package adc_pkg;

  typedef enum logic [1:0] {SAR_IDLE, SAR_SAMPLE, SAR_CONVERT} sar_phase_t;

  typedef struct packed {
    sar_phase_t  phase;
    logic [3:0]  cnt;
    logic [2:0]  bit_idx;
    logic [7:0]  code;
    logic [7:0]  result;
    logic        done;
  } sar_state_t;

  typedef struct packed {
    logic        run;
    logic [2:0]  chan;
    logic [7:0]  result;
    logic        result_valid;
    logic        flag;
    logic [1:0]  mask;
    logic        dac_en;
    logic [31:0] prdata;
    logic        pend;
    logic [7:0]  pend_data;
    logic        cmp_meta;
    logic        cmp_sync;
    logic        irq_pulse;
  } ctrl_state_t;

endpackage

/* adc_sar_engine.sv */
// Purpose: Successive approximation sequencer, sample then 8 trials
// Assumes: Comparator level already synchronised
// Notes:   Abort returns to idle in one cycle
`timescale 1ns/10ps
`default_nettype none
`include "adc_cfg.svh"

module adc_sar_engine
  import adc_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       start,
  input  wire logic       abort,
  input  wire logic       cmp_high,
  output logic            busy,
  output logic            sampling,
  output logic [7:0]      trial_code,
  output logic            done,
  output logic [7:0]      result
);

  sar_state_t st_ff;
  sar_state_t nxt_st;

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.done = 1'b0;
    if (abort) begin
      nxt_st.phase = SAR_IDLE;
    end else begin
      unique case (st_ff.phase)
        SAR_IDLE: begin
          if (start) begin
            nxt_st.phase = SAR_SAMPLE;
            nxt_st.cnt   = 4'h0;
          end
        end
        SAR_SAMPLE: begin
          nxt_st.cnt = st_ff.cnt + 4'h1;
          if (st_ff.cnt == `SAMPLE_CYCLES - 4'h1) begin
            nxt_st.phase   = SAR_CONVERT;
            nxt_st.bit_idx = `SAR_MSB;
            nxt_st.code    = `SAR_FIRST_CODE;
          end
        end
        SAR_CONVERT: begin
          // Trial bit stays only if the input is above the trial level
          nxt_st.code[st_ff.bit_idx] = cmp_high;
          if (st_ff.bit_idx == 3'h0) begin
            nxt_st.result = {st_ff.code[7:1], cmp_high};
            nxt_st.done   = 1'b1;
            nxt_st.phase  = SAR_IDLE;
          end else begin
            nxt_st.bit_idx                    = st_ff.bit_idx - 3'h1;
            nxt_st.code[st_ff.bit_idx - 3'h1] = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '{phase: SAR_IDLE, cnt: 4'h0, bit_idx: 3'h0, code: 8'h00,
                 result: 8'h00, done: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign busy       = (st_ff.phase != SAR_IDLE);
  assign sampling   = (st_ff.phase == SAR_SAMPLE);
  assign trial_code = st_ff.code;
  assign done       = st_ff.done;
  assign result     = st_ff.result;

endmodule // adc_sar_engine
`default_nettype wire

/* adc_result_flag_arbitration.sv */
// Purpose: Run control, result arbitration and done flag of the converter
// Assumes: APB slave, zero wait; standby level is on pclk
// Notes:   Emulation helper register only drives its own pin
//
// Behaviour
// R01: Standby stops all conversion activity.
// R02: Clearing the run bit stops conversion.
// R03: Coincident result read completes before store.
// R04: Control write at end drops result, irq.
// R05: Channel rewrite leaves done flag untouched.
// R06: Old channel result may still land.
// R07: Software clears flag before restarting.
// R08: Result undefined after control writes.
// R09: Software reads result before control writes.
// R10: No port reads on converting pin.
// R11: Emulation helper register is write only.
// R12: Software sets helper enable for power-fail.
// R13: Software writes zero to helper bits 7:1.
// R14: Helper register never alters converter behaviour.
// R15: Run bit set restarts conversions back to back.
// R16: Control write aborts, restarts if running.
// R17: Completed conversion stores result, raises irq.
// R18: Channel codes 0 to 4 only.
// R19: Done flag sticky until software clears.
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "adc_cfg.svh"

module adc_result_flag_arbitration
  import adc_pkg::*;
(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [`ADDR_W-1:0]  paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                standby,
  input  wire logic                comparator_in,
  output logic [2:0]               analog_mux_sel,
  output logic                     sample_hold,
  output logic [7:0]               dac_trial_code,
  output logic                     conversion_done_irq,
  output logic                     irq,
  output logic                     emulator_dac_enable
);

  // ----------------------------------------------------------------
  // State and bus decode
  // ----------------------------------------------------------------
  ctrl_state_t st_ff;
  ctrl_state_t nxt_st;

  logic        setup;
  logic        access;
  logic        wr;
  logic        rd;
  logic        hit_mode;
  logic        hit_chan;
  logic        hit_result;
  logic        hit_status;
  logic        hit_mask;
  logic        hit_dac;
  logic        mapped;
  logic        chan_bad;
  logic        ctl_wr;
  logic        res_rd;
  logic        sar_busy;
  logic        sar_sampling;
  logic        sar_done;
  logic [7:0]  sar_result;
  logic [7:0]  sar_code;
  logic        sar_start;
  logic        sar_abort;
  logic        store_now;

  assign setup      = psel & ~penable;
  assign access     = psel & penable;
  assign wr         = access & pwrite;
  assign rd         = access & ~pwrite;
  assign hit_mode   = (paddr == `OFF_MODE);
  assign hit_chan   = (paddr == `OFF_CHAN);
  assign hit_result = (paddr == `OFF_RESULT);
  assign hit_status = (paddr == `OFF_STATUS);
  assign hit_mask   = (paddr == `OFF_MASK);
  assign hit_dac    = (paddr == `OFF_DAC_MODE);
  assign mapped     = hit_mode | hit_chan | hit_result | hit_status | hit_mask | hit_dac;
  // Prohibited channel codes are refused, the old channel stays
  assign chan_bad   = hit_chan & pwrite & (pwdata[`CHAN_MSB:0] > `CHAN_MAX);
  assign ctl_wr     = wr & (hit_mode | (hit_chan & ~chan_bad));
  assign res_rd     = rd & hit_result;

  assign pready  = 1'b1;
  assign pslverr = access & (~mapped | chan_bad | (hit_dac & ~pwrite));

  // ----------------------------------------------------------------
  // Conversion sequencing
  // ----------------------------------------------------------------
  // Abort covers standby, stop and every control write
  assign sar_abort = standby | ctl_wr | ~st_ff.run; // R01 R02 R16
  assign sar_start = st_ff.run & ~standby & ~ctl_wr; // R15

  adc_sar_engine u_sar (
    .pclk       (pclk),
    .presetn    (presetn),
    .start      (sar_start),
    .abort      (sar_abort),
    .cmp_high   (st_ff.cmp_sync),
    .busy       (sar_busy),
    .sampling   (sar_sampling),
    .trial_code (sar_code),
    .done       (sar_done),
    .result     (sar_result)
  );

  // A control write landing on the end cycle wins; a read defers the store
  assign store_now = sar_done & ~ctl_wr & ~res_rd; // R04 R03

  always_comb begin
    nxt_st           = st_ff;
    nxt_st.cmp_meta  = comparator_in;
    nxt_st.cmp_sync  = st_ff.cmp_meta;
    nxt_st.irq_pulse = 1'b0;
    nxt_st.pend      = 1'b0;

    if (setup) begin
      unique case (1'b1)
        hit_mode:   nxt_st.prdata = {24'h00_0000, st_ff.run, 7'h00};
        hit_chan:   nxt_st.prdata = {29'h0000_0000, st_ff.chan};
        hit_result: nxt_st.prdata = {24'h00_0000, st_ff.result};
        hit_status: nxt_st.prdata = {30'h0000_0000, st_ff.result_valid, st_ff.flag};
        hit_mask:   nxt_st.prdata = {30'h0000_0000, st_ff.mask};
        default:    nxt_st.prdata = `RD_ZERO; // R11
      endcase
    end

    if (wr) begin
      if (hit_mode) begin
        nxt_st.run = pwdata[`RUN_BIT]; // R02
      end
      if (hit_chan && !chan_bad) begin
        nxt_st.chan = pwdata[`CHAN_MSB:0]; // R18
      end
      // Only a status write clears the flag, never a channel write
      if (hit_status && pwdata[`DONE_BIT]) begin // R05
        nxt_st.flag = 1'b0;
      end
      if (hit_mask) begin
        nxt_st.mask = pwdata[1:0];
      end
      if (hit_dac) begin
        // Only bit 0 is kept; it reaches nothing but its own pin
        nxt_st.dac_en = pwdata[`DAC_EN_BIT]; // R14
      end
    end

    if (ctl_wr) begin
      nxt_st.result_valid = 1'b0; // R08
    end

    if (sar_done && res_rd && !ctl_wr) begin
      nxt_st.pend      = 1'b1; // R03
      nxt_st.pend_data = sar_result;
    end

    if (store_now || (st_ff.pend && !ctl_wr)) begin
      nxt_st.result       = store_now ? sar_result : st_ff.pend_data; // R17 R06
      nxt_st.result_valid = 1'b1;
      nxt_st.irq_pulse    = 1'b1;
      // Set beats a same-cycle clear
      nxt_st.flag         = 1'b1; // R19
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '{run: 1'b0, chan: `RST_CHAN, result: `RST_RESULT, result_valid: 1'b0,
                 flag: 1'b0, mask: 2'h0, dac_en: 1'b0, prdata: `RD_ZERO, pend: 1'b0,
                 pend_data: 8'h00, cmp_meta: 1'b0, cmp_sync: 1'b0, irq_pulse: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata              = st_ff.prdata;
  assign analog_mux_sel      = st_ff.chan;
  assign sample_hold         = sar_sampling;
  assign dac_trial_code      = sar_code;
  assign conversion_done_irq = st_ff.irq_pulse;
  // Mask bit 1 would only gate the valid bit, which never interrupts
  assign irq                 = st_ff.flag & st_ff.mask[`DONE_BIT];
  assign emulator_dac_enable = st_ff.dac_en;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_standby_stops: assert property (standby |=> !sar_busy) // R01
    else $error("conversion runs in standby");

  a_run_clear_stop: assert property (wr && hit_mode && !pwdata[`RUN_BIT] |=> !sar_busy [*2]) // R02
    else $error("conversion continues after run cleared");

  a_read_first: assert property (sar_done && res_rd && !ctl_wr
                                 |=> $stable(st_ff.result) ##1 st_ff.result == $past(sar_result, 2)) // R03
    else $error("result stored before coincident read");

  a_write_wins: assert property (sar_done && ctl_wr
                                 |=> !st_ff.irq_pulse && $stable(st_ff.result) && !st_ff.pend) // R04
    else $error("result stored despite control write");

  a_chan_keeps_flag: assert property (wr && hit_chan && st_ff.flag |=> st_ff.flag) // R05
    else $error("channel write cleared done flag");

  a_done_store: assert property (store_now
                                 |=> st_ff.result == $past(sar_result) && st_ff.irq_pulse) // R17
    else $error("completed conversion not stored");

  a_flag_sticky: assert property (st_ff.flag && !(wr && hit_status && pwdata[`DONE_BIT])
                                  |=> st_ff.flag) // R19
    else $error("done flag dropped without clear");

  a_back_to_back: assert property (sar_done && st_ff.run && !standby && !ctl_wr
                                   |=> sar_busy) // R15
    else $error("no restart after completion");

  a_abort_restart: assert property (ctl_wr && sar_busy
                                    && (hit_chan ? st_ff.run : pwdata[`RUN_BIT])
                                    |=> !sar_busy ##1 (sar_busy || standby)) // R16
    else $error("control write did not restart conversion");

  a_helper_wo: assert property (rd && hit_dac |-> prdata == `RD_ZERO) // R11
    else $error("helper register read back");

  a_chan_legal: assert property (st_ff.chan <= `CHAN_MAX) // R18
    else $error("prohibited channel selected");

  a_invalid_after: assert property (ctl_wr |=> !st_ff.result_valid) // R08
    else $error("result valid after control write");

  c_store: cover property (store_now ##1 irq);
  c_write_wins: cover property (sar_done && ctl_wr);
  c_read_coincide: cover property (sar_done && res_rd);
  c_flag_clear: cover property (st_ff.flag ##1 !st_ff.flag);

endmodule // adc_result_flag_arbitration
`default_nettype wire

/* adc_result_flag_arbitration_tb.sv */
// Purpose: Self-checking bench of the converter control block
// Assumes: Zero-wait APB slave; conversion length measured once, then reused
// Notes:   Driver queues expected answers, monitor pops them per transfer
`timescale 1ns/10ps
`default_nettype none
`include "adc_cfg.svh"
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("[FAIL] %0t got %h expected %h", $time, got, exp); end end

module adc_result_flag_arbitration_tb
  import adc_pkg::*;
;
  typedef struct packed {logic is_rd; logic err; logic [31:0] data;} note_t;
  logic               pclk, presetn, psel, penable, pwrite, standby, comparator_in;
  logic [`ADDR_W-1:0] paddr;
  logic [31:0]        pwdata, prdata;
  logic               pready, pslverr, sample_hold, conversion_done_irq, irq;
  logic               emulator_dac_enable, cmp;
  logic [2:0]         analog_mux_sel, ch;
  logic [7:0]         dac_trial_code;
  note_t              notes[$];
  int                 mismatches, num_checks, seed, d, n;

  adc_result_flag_arbitration dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .standby(standby), .comparator_in(comparator_in),
    .analog_mux_sel(analog_mux_sel), .sample_hold(sample_hold),
    .dac_trial_code(dac_trial_code), .conversion_done_irq(conversion_done_irq),
    .irq(irq), .emulator_dac_enable(emulator_dac_enable));

  always #5 pclk = ~pclk;

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Bus driver and monitor
  // ----------------------------------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] dat,
                      input logic err);
    int k;
    @(posedge pclk);
    notes.push_back({!w, err, dat});
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= w ? dat : 32'($random(seed));
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      mismatches++;
      tally_and_finish();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dat, input logic err);
    xfer(1'b1, a, dat, err);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] dat, input logic err);
    xfer(1'b0, a, dat, err);
  endtask

  // Bounded wait for the done pulse; leaves the last sampled level for a check
  task automatic wait_irq(input int lim);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (conversion_done_irq !== 1'b1 && n < lim);
  endtask

  always @(posedge pclk) begin : monitor
    note_t e;
    if (presetn && psel && penable && pready) begin
      if (notes.size() == 0) begin
        mismatches++;
        $display("[FAIL] %0t transfer without expectation", $time);
      end else begin
        e = notes.pop_front();
        `CHK(pslverr, e.err)
        if (e.is_rd)
          `CHK(prdata, e.data)
      end
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
    standby = 0; seed = 64113;
    cmp = 1'($random(seed));
    ch = 3'(($random(seed) & 32'h7fff_ffff) % 5);
    comparator_in = cmp;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(`OFF_MODE, `RD_ZERO, 0);
    rd(`OFF_CHAN, `RD_ZERO, 0);
    rd(`OFF_RESULT, `RD_ZERO, 0);
    rd(`OFF_STATUS, `RD_ZERO, 0);
    rd(`OFF_MASK, `RD_ZERO, 0);
    rd(8'h18, `RD_ZERO, 1);
    wr(`OFF_DAC_MODE, 32'h0000_0001, 0);
    @(negedge pclk) `CHK(emulator_dac_enable, 1'b1)
    rd(`OFF_DAC_MODE, `RD_ZERO, 1);
    wr(`OFF_CHAN, 32'h0000_0005, 1);
    for (int c = 0; c < 5; c++) begin
      wr(`OFF_CHAN, 32'(c), 0);
      @(negedge pclk) `CHK(analog_mux_sel, 3'(c))
    end
    wr(`OFF_CHAN, {29'h0, ch}, 0);
    wr(`OFF_MASK, 32'h0000_0001, 0);
    $display("test map done");
    // Helper enable left set: conversions below must be unaffected
    wr(`OFF_MODE, 32'h0000_0080, 0);
    wait_irq(200); `CHK(conversion_done_irq, 1'b1)
    d = n - 1;
    rd(`OFF_RESULT, {24'h0, {8{cmp}}}, 0);
    rd(`OFF_STATUS, 32'h0000_0003, 0);
    @(negedge pclk) `CHK(irq, 1'b1)
    wr(`OFF_MASK, `RD_ZERO, 0);
    @(negedge pclk) `CHK(irq, 1'b0)
    wr(`OFF_MASK, 32'h0000_0001, 0);
    wait_irq(200); `CHK(conversion_done_irq, 1'b1)
    wr(`OFF_CHAN, {29'h0, 3'((ch + 1) % 5)}, 0);
    rd(`OFF_STATUS, 32'h0000_0001, 0);
    wr(`OFF_MODE, `RD_ZERO, 0);
    wr(`OFF_STATUS, 32'h0000_0001, 0);
    rd(`OFF_STATUS, `RD_ZERO, 0);
    wait_irq(3 * d); `CHK(conversion_done_irq, 1'b0)
    `CHK(sample_hold, 1'b0)
    $display("test run done");
    standby <= 1'b1;
    wr(`OFF_MODE, 32'h0000_0080, 0);
    wait_irq(3 * d); `CHK(conversion_done_irq, 1'b0)
    `CHK(sample_hold, 1'b0)
    standby <= 1'b0;
    repeat (2) @(negedge pclk);
    `CHK(sample_hold, 1'b1)
    repeat (8) @(negedge pclk);
    `CHK(dac_trial_code, `SAR_FIRST_CODE)
    wait_irq(3 * d); `CHK(conversion_done_irq, 1'b1)
    wr(`OFF_MODE, `RD_ZERO, 0);
    wr(`OFF_STATUS, 32'h0000_0001, 0);
    comparator_in <= ~cmp;
    $display("test standby done");
    // Read access lands on the store edge: old value out, new value after
    wr(`OFF_MODE, 32'h0000_0080, 0);
    repeat (d - 3) @(posedge pclk);
    rd(`OFF_RESULT, {24'h0, {8{cmp}}}, 0);
    wait_irq(5); `CHK(conversion_done_irq, 1'b1)
    rd(`OFF_RESULT, {24'h0, {8{~cmp}}}, 0);
    wr(`OFF_MODE, `RD_ZERO, 0);
    wr(`OFF_STATUS, 32'h0000_0001, 0);
    // Channel write lands on the store edge: no store, no pulse, restart
    wr(`OFF_MODE, 32'h0000_0080, 0);
    repeat (d - 3) @(posedge pclk);
    wr(`OFF_CHAN, {29'h0, ch}, 0);
    rd(`OFF_STATUS, `RD_ZERO, 0);
    wait_irq(d - 5); `CHK(conversion_done_irq, 1'b0)
    wait_irq(12); `CHK(conversion_done_irq, 1'b1)
    $display("test contention done");
    tally_and_finish();
  end

endmodule // adc_result_flag_arbitration_tb
`undef CHK
`default_nettype wire
